// ===== include/ddpu_pkg.sv
// Constants for the dual data pointer unit
package ddpu_pkg;

   // ----------------------------------------------------------------
   // Special-function register addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_PTR0_LOW  = 8'h82;
   localparam logic [7:0] ADDR_PTR0_HIGH = 8'h83;
   localparam logic [7:0] ADDR_PTR1_LOW  = 8'h84;
   localparam logic [7:0] ADDR_PTR1_HIGH = 8'h85;
   localparam logic [7:0] ADDR_PTR_SEL   = 8'h86;

   // ----------------------------------------------------------------
   // Widths, fields and reset values
   // ----------------------------------------------------------------
   localparam int          BYTE_W        = 8;
   localparam int          PTR_W         = 16;
   localparam int          SEL_BIT       = 0;
   localparam logic [7:0]  SEL_RESET     = 8'h00;
   localparam logic [15:0] PTR_RESET     = 16'h0000;
   localparam logic [15:0] PTR_STEP      = 16'h0001;
   localparam logic [7:0]  BYTE_ZERO     = 8'h00;
   localparam logic [15:0] ADDR_ZERO     = 16'h0000;

endpackage : ddpu_pkg

// ===== rtl/ddpu_dual_pointer.sv
// Dual data pointer bank with select register and move address path
//
// What this block does
// - An indirect byte move takes its low address byte from the working register and its high byte from the Port 2 latch.
// - Each data pointer is a 16-bit register giving a full absolute address over the 64 kB data space.
// - Two independent pointers exist, and a pointer move drives its address from the active one.
// - The first pointer sits at special-function addresses 82h (low) and 83h (high).
// - The second pointer sits at special-function addresses 84h (low) and 85h (high).
// - The pointer select bit is the least significant bit of the register at 86h.
// - The upper bits of the register at 86h do nothing and always hold zero.
// - Select bit 0 makes the first pointer active and select bit 1 the second.
// - Loading, incrementing and moving through the pointer act only on the selected pointer.
// - Incrementing the select register flips bit zero while the other bits stay zero.
`timescale 1ns/1ps

module ddpu_dual_pointer
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Special-function register port from the core
   input  wire logic [7:0]  sfr_addr,
   input  wire logic        sfr_wr,
   input  wire logic [7:0]  sfr_wdata,
   input  wire logic        sfr_rd,
   output logic      [7:0]  sfr_rdata,
   output logic             sfr_hit,
   // Pointer instructions from the core
   input  wire logic        ptr_load,
   input  wire logic [15:0] ptr_load_value,
   input  wire logic        ptr_inc,
   // External data move request
   input  wire logic        xmove_req,
   input  wire logic        indirect_register_mode,
   input  wire logic [7:0]  work_reg,
   input  wire logic [7:0]  port2_latch,
   output logic      [15:0] xmem_addr,
   output logic             xmem_addr_valid,
   // Currently selected pointer
   output logic      [15:0] data_pointer,
   output logic             pointer_select
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [15:0] primary_pointer_reg;
   logic [15:0] secondary_pointer_reg;
   logic [7:0]  pointer_select_reg;
   logic [7:0]  pointer_select_next;
   logic [15:0] active_next;
   logic        active_write;
   logic        sel_hit;
   logic        p0_lo_hit;
   logic        p0_hi_hit;
   logic        p1_lo_hit;
   logic        p1_hi_hit;
   logic        addr_mapped;
   logic [7:0]  read_mux;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // Register hits by address
   // pointer and select register decode
   assign p0_lo_hit   = (sfr_addr == ddpu_pkg::ADDR_PTR0_LOW);
   assign p0_hi_hit   = (sfr_addr == ddpu_pkg::ADDR_PTR0_HIGH);
   assign p1_lo_hit   = (sfr_addr == ddpu_pkg::ADDR_PTR1_LOW);
   assign p1_hi_hit   = (sfr_addr == ddpu_pkg::ADDR_PTR1_HIGH);
   assign sel_hit     = (sfr_addr == ddpu_pkg::ADDR_PTR_SEL);
   assign addr_mapped = p0_lo_hit | p0_hi_hit | p1_lo_hit | p1_hi_hit | sel_hit;

   // ----------------------------------------------------------------
   // Pointer selection
   // ----------------------------------------------------------------
   // bit zero picks the pointer
   assign pointer_select = pointer_select_reg[ddpu_pkg::SEL_BIT];
   assign data_pointer   = pointer_select ? secondary_pointer_reg : primary_pointer_reg;

   // Select register keeps only bit zero
   always_comb
   begin
      pointer_select_next = ddpu_pkg::BYTE_ZERO;
      pointer_select_next[ddpu_pkg::SEL_BIT] = sfr_wdata[ddpu_pkg::SEL_BIT];
   end

   // Instruction update of the active pointer
   always_comb
   begin
      active_write = 1'b1;
      active_next  = data_pointer;
      if (ptr_load)
      begin
         active_next = ptr_load_value;
      end
      else if (ptr_inc)
      begin
         active_next = 16'(data_pointer + ddpu_pkg::PTR_STEP);   // Wraps at 64 kB
      end
      else
      begin
         active_write = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Select register
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         pointer_select_reg <= ddpu_pkg::SEL_RESET;
      end
      else if (sfr_wr && sel_hit)
      begin
         pointer_select_reg <= pointer_select_next;
      end
   end

   // First pointer: instruction update wins over byte write
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         primary_pointer_reg <= ddpu_pkg::PTR_RESET;
      end
      else if (active_write && !pointer_select)
      begin
         primary_pointer_reg <= active_next;
      end
      else if (sfr_wr && p0_lo_hit)
      begin
         primary_pointer_reg[ddpu_pkg::BYTE_W-1:0] <= sfr_wdata;
      end
      else if (sfr_wr && p0_hi_hit)
      begin
         primary_pointer_reg[ddpu_pkg::PTR_W-1:ddpu_pkg::BYTE_W] <= sfr_wdata;
      end
   end

   // Second pointer: instruction update wins over byte write
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         secondary_pointer_reg <= ddpu_pkg::PTR_RESET;
      end
      else if (active_write && pointer_select)
      begin
         secondary_pointer_reg <= active_next;
      end
      else if (sfr_wr && p1_lo_hit)
      begin
         secondary_pointer_reg[ddpu_pkg::BYTE_W-1:0] <= sfr_wdata;
      end
      else if (sfr_wr && p1_hi_hit)
      begin
         secondary_pointer_reg[ddpu_pkg::PTR_W-1:ddpu_pkg::BYTE_W] <= sfr_wdata;
      end
   end

   // ----------------------------------------------------------------
   // Register read
   // ----------------------------------------------------------------
   // Read data multiplexer
   always_comb
   begin
      read_mux = ddpu_pkg::BYTE_ZERO;
      if (p0_lo_hit)
      begin
         read_mux = primary_pointer_reg[ddpu_pkg::BYTE_W-1:0];
      end
      else if (p0_hi_hit)
      begin
         read_mux = primary_pointer_reg[ddpu_pkg::PTR_W-1:ddpu_pkg::BYTE_W];
      end
      else if (p1_lo_hit)
      begin
         read_mux = secondary_pointer_reg[ddpu_pkg::BYTE_W-1:0];
      end
      else if (p1_hi_hit)
      begin
         read_mux = secondary_pointer_reg[ddpu_pkg::PTR_W-1:ddpu_pkg::BYTE_W];
      end
      else if (sel_hit)
      begin
         read_mux = pointer_select_reg;
      end
   end

   // Registered read answer, zero when unmapped
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         sfr_rdata <= ddpu_pkg::BYTE_ZERO;
         sfr_hit   <= 1'b0;
      end
      else if (sfr_rd)
      begin
         sfr_rdata <= read_mux;
         sfr_hit   <= addr_mapped;
      end
      else
      begin
         sfr_rdata <= ddpu_pkg::BYTE_ZERO;
         sfr_hit   <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // External move address
   // ----------------------------------------------------------------
   // Address issued one cycle after the request
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         xmem_addr       <= ddpu_pkg::ADDR_ZERO;
         xmem_addr_valid <= 1'b0;
      end
      else
      begin
         xmem_addr_valid <= xmove_req;
         if (xmove_req && indirect_register_mode)
         begin
            xmem_addr <= {port2_latch, work_reg};
         end
         else if (xmove_req)
         begin
            xmem_addr <= data_pointer;
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   indirect_addr_a: assert property (
      xmove_req && indirect_register_mode |=>
         xmem_addr_valid && xmem_addr == {$past(port2_latch), $past(work_reg)})
      else $error("indirect move address wrong");

   pointer_wrap_a: assert property (
      ptr_inc && !ptr_load && !(sfr_wr && sel_hit) && data_pointer == 16'hFFFF
         |=> data_pointer == 16'h0000)
      else $error("pointer did not wrap over 64 kB");

   pointer_move_a: assert property (
      xmove_req && !indirect_register_mode |=> xmem_addr == $past(data_pointer))
      else $error("pointer move address not the active pointer");

   first_ptr_map_a: assert property (
      sfr_wr && sfr_addr == 8'h83 && !ptr_load && !ptr_inc ##1 sfr_rd && sfr_addr == 8'h83
         |=> sfr_hit && sfr_rdata == $past(sfr_wdata, 2))
      else $error("first pointer high byte not at 83h");

   second_ptr_map_a: assert property (
      sfr_wr && sfr_addr == 8'h84 && !ptr_load && !ptr_inc |=>
         secondary_pointer_reg[7:0] == $past(sfr_wdata))
      else $error("second pointer low byte not at 84h");

   select_bit_a: assert property (
      sfr_wr && sfr_addr == 8'h86 |=> pointer_select == $past(sfr_wdata[0]))
      else $error("select bit not taken from bit zero of 86h");

   select_upper_a: assert property (
      pointer_select_reg[7:1] == 7'h00)
      else $error("select register upper bits not zero");

   select_meaning_a: assert property (
      sfr_wr && sel_hit && !ptr_load && !ptr_inc |=> data_pointer ==
         ($past(sfr_wdata[0]) ? $past(secondary_pointer_reg) : $past(primary_pointer_reg)))
      else $error("wrong pointer active for select value");

   load_isolated_a: assert property (
      ptr_load && !pointer_select && !(sfr_wr && (p1_lo_hit || p1_hi_hit)) |=>
         primary_pointer_reg == $past(ptr_load_value)
         && $stable(secondary_pointer_reg))
      else $error("load touched the unselected pointer");

   inc_isolated_a: assert property (
      ptr_inc && !ptr_load && pointer_select && !(sfr_wr && (p0_lo_hit || p0_hi_hit)) |=>
         secondary_pointer_reg == $past(secondary_pointer_reg) + 16'h0001
         && $stable(primary_pointer_reg))
      else $error("increment touched the unselected pointer");

   select_toggle_a: assert property (
      sfr_wr && sfr_addr == 8'h86 && sfr_wdata == pointer_select_reg + 8'h01 |=>
         pointer_select != $past(pointer_select) && pointer_select_reg[7:1] == 7'h00)
      else $error("select increment did not toggle");

   reset_clear_a: assert property (@(posedge clk) disable iff (1'b0)
      sys_rst |=> pointer_select_reg == 8'h00 && primary_pointer_reg == 16'h0000
         && secondary_pointer_reg == 16'h0000)
      else $error("reset did not clear the pointer bank");

   switch_cover_c:   cover property (sfr_wr && sfr_addr == 8'h86 ##1 $changed(pointer_select));
   second_move_c:    cover property (pointer_select && xmove_req && !indirect_register_mode);
   indirect_move_c:  cover property (xmove_req && indirect_register_mode);
   block_move_c:     cover property (ptr_inc && pointer_select ##[1:10] ptr_inc && !pointer_select);

endmodule : ddpu_dual_pointer

// ===== testbench/ddpu_xmem_model.sv
// Behavioural model of the off-chip data memory addressed by moves
`timescale 1ns/1ps

module ddpu_xmem_model
(
   input  wire logic        clk,
   input  wire logic [15:0] xmem_addr,
   input  wire logic        xmem_addr_valid,
   output int               access_count
);
   int count_reg = 0;

   // Count each strobed access that carries a clean address
   assign access_count = count_reg;
   always @(posedge clk)
   begin
      if (xmem_addr_valid === 1'b1 && !$isunknown(xmem_addr))
      begin
         count_reg <= count_reg + 1;
      end
   end
endmodule : ddpu_xmem_model

// ===== testbench/ddpu_tb.sv
// Self-checking bench for the dual data pointer unit
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin err_total++; \
   $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end

module dual_data_pointer_unit_tb;
   logic        clk, sys_rst, sfr_wr, sfr_rd, sfr_hit, ptr_load, ptr_inc, pointer_select;
   logic        xmove_req, indirect_register_mode, xmem_addr_valid, rd_taken, m_sel;
   logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, work_reg, port2_latch, rnd;
   logic [15:0] ptr_load_value, xmem_addr, data_pointer, got_mv;
   logic [15:0] m_ptr [2];
   logic [8:0]  got_rd;
   logic [8:0]  rd_q [$];
   logic [15:0] mv_q [$];
   int          err_total, cmp_count, moves, model_count;

   ddpu_dual_pointer ddpu_dual_pointer_i (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
      .sfr_hit(sfr_hit), .ptr_load(ptr_load), .ptr_load_value(ptr_load_value),
      .ptr_inc(ptr_inc), .xmove_req(xmove_req), .indirect_register_mode(indirect_register_mode),
      .work_reg(work_reg), .port2_latch(port2_latch), .xmem_addr(xmem_addr),
      .xmem_addr_valid(xmem_addr_valid), .data_pointer(data_pointer),
      .pointer_select(pointer_select));
   ddpu_xmem_model ddpu_xmem_model_i (.clk(clk), .xmem_addr(xmem_addr),
      .xmem_addr_valid(xmem_addr_valid), .access_count(model_count));

   // Clock at 100 ns
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr_next

   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict

   // Reset held n cycles, all inputs quiet
   task automatic do_reset(input int n);
      sys_rst = 1'b1;
      {sfr_wr, sfr_rd, ptr_load, ptr_inc, xmove_req, indirect_register_mode} = 6'h00;
      {sfr_addr, sfr_wdata, work_reg, port2_latch, ptr_load_value} = 48'h0;
      repeat (n) @(negedge clk);
      sys_rst = 1'b0;
      m_ptr[0] = 16'h0000;
      m_ptr[1] = 16'h0000;
      m_sel = 1'b0;
   endtask : do_reset

   // One core cycle: drive, note expectations, update the model
   task automatic cyc(input logic w, r, input logic [7:0] a, d, input logic ld, inc,
                      input logic [15:0] lv, input logic mv, md);
      logic [7:0] rv;
      rnd = lfsr_next(rnd);
      {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {w, r, a, d};
      {ptr_load, ptr_inc, ptr_load_value} = {ld, inc, lv};
      {xmove_req, indirect_register_mode, work_reg} = {mv, md, rnd};
      port2_latch = lfsr_next(rnd);
      case (a)
         ddpu_pkg::ADDR_PTR0_LOW:  rv = m_ptr[0][7:0];
         ddpu_pkg::ADDR_PTR0_HIGH: rv = m_ptr[0][15:8];
         ddpu_pkg::ADDR_PTR1_LOW:  rv = m_ptr[1][7:0];
         ddpu_pkg::ADDR_PTR1_HIGH: rv = m_ptr[1][15:8];
         ddpu_pkg::ADDR_PTR_SEL:   rv = {7'h00, m_sel};
         default:                  rv = 8'h00;
      endcase
      if (r)
         rd_q.push_back({a >= 8'h82 && a <= 8'h86, rv});
      if (mv)
         mv_q.push_back(md ? {port2_latch, work_reg} : m_ptr[m_sel]);
      moves += mv;
      if (ld)
         m_ptr[m_sel] = lv;
      else if (inc)
         m_ptr[m_sel] = m_ptr[m_sel] + 16'h0001;
      if (w && a == 8'h86)
         m_sel = d[0];
      // Instruction beats a byte write to the pointer it changes
      if (w && a >= 8'h82 && a <= 8'h85 && !((ld || inc) && a[2] == m_sel))
         m_ptr[a[2]][a[0]*8 +: 8] = d;
      @(negedge clk);
      `CHK("selected pointer", m_ptr[m_sel], data_pointer)
      `CHK("select output", m_sel, pointer_select)
   endtask : cyc

   task automatic rd(input logic [7:0] a);
      cyc(1'b0, 1'b1, a, 8'h00, 1'b0, 1'b0, 16'h0000, 1'b0, 1'b0);
   endtask : rd

   task automatic wr(input logic [7:0] a, d);
      cyc(1'b1, 1'b0, a, d, 1'b0, 1'b0, 16'h0000, 1'b0, 1'b0);
   endtask : wr

   // Watcher: compare answers with the oldest notes
   always @(posedge clk) rd_taken <= sfr_rd && !sys_rst;
   always @(negedge clk)
   begin
      got_rd = rd_taken ? rd_q.pop_front() : 9'h000;
      `CHK("read data", got_rd[7:0], sfr_rdata)
      `CHK("read hit", got_rd[8], sfr_hit)
      if (xmem_addr_valid !== 1'b0)
      begin
         got_mv = mv_q.pop_front();
         `CHK("move address", got_mv, xmem_addr)
      end
   end

   // Watchdog
   initial
   begin
      repeat (3000) @(posedge clk);
      err_total++;
      give_verdict();
   end

   // Main sequence
   initial
   begin
      {err_total, cmp_count, moves, rnd} = {32'd0, 32'd0, 32'd0, 8'h39};
      do_reset(16);
      for (int a = 8'h81; a <= 8'h87; a++) rd(a[7:0]);
      rd(8'hFF);
      for (int a = 8'h82; a <= 8'h85; a++) wr(a[7:0], rnd);
      for (int a = 8'h82; a <= 8'h85; a++) rd(a[7:0]);
      wr(8'h86, 8'hFF);
      rd(8'h86);
      cyc(1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0, 16'h0000, 1'b1, 1'b0);
      repeat (3)
      begin
         wr(8'h86, {7'h00, m_sel} + 8'h01);
         cyc(1'b0, 1'b1, 8'h86, 8'h00, 1'b0, 1'b0, 16'h0000, 1'b1, 1'b0);
      end
      // load, wrap, priority, move sees old value
      cyc(1'b0, 1'b0, 8'h00, 8'h00, 1'b1, 1'b0, 16'hFFFF, 1'b1, 1'b0);
      cyc(1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 1'b1, 16'h0000, 1'b1, 1'b0);
      cyc(1'b0, 1'b0, 8'h00, 8'h00, 1'b1, 1'b1, 16'hA5C3, 1'b1, 1'b0);
      // load beats byte write, increment on the second pointer
      cyc(1'b1, 1'b0, 8'h82, 8'h5A, 1'b1, 1'b0, 16'h1234, 1'b0, 1'b0);
      wr(8'h83, rnd);
      rd(8'h83);
      wr(8'h86, {7'h00, m_sel} + 8'h01);
      cyc(1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 1'b1, 16'h0000, 1'b1, 1'b0);
      wr(8'h86, {7'h00, m_sel} + 8'h01);
      cyc(1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 1'b1, 16'h0000, 1'b1, 1'b0);
      for (int a = 8'h82; a <= 8'h86; a++) rd(a[7:0]);
      // random indirect and pointer moves mixed with reads
      repeat (12) cyc(1'b0, rnd[0], 8'h80 + {5'h00, rnd[3:1]}, 8'h00, 1'b0, 1'b0,
                      16'h0000, 1'b1, rnd[4]);
      do_reset(2);
      for (int a = 8'h82; a <= 8'h86; a++) rd(a[7:0]);
      repeat (3) cyc(1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0, 16'h0000, 1'b0, 1'b0);
      `CHK("memory accesses", moves, model_count)
      give_verdict();
   end
endmodule : dual_data_pointer_unit_tb
